// ---- core/i2c_reg_host.sv ----
// two-wire bus master doing single-register writes and reads on one slave
// assumes pull-ups on the wires; sda is open drain, scl is only ever driven by us
// Contract
// - data changes only while clock low
// - master alone makes the clock
// - master changes data after clock falls
// - eight bits msb first, then ack slot
// - any byte count between start and stop
// - receiver acknowledges each byte low
// - slave nack on write ends with stop
// - master nacks last read byte, then stops
// - master clocks every acknowledge slot
// - first byte: seven-bit address plus direction
// - write: addr, register, data, stop
// - read: addr, register, restart, addr, data
// - start falls, stop rises, clock high
// - slave only, up to 100 kbit/s
`timescale 1ns/1ns
module i2c_reg_host (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // synchronous reset
    input i2c_host_pkg::req_t req, // transfer request, taken when ready
    output i2c_host_pkg::rsp_t rsp, // status and read data
    input wire logic sdaIn, // data wire level
    output logic sdaOut, // data drive value, always low
    output logic sdaOe, // pull data low when high
    output logic sclOut // clock wire
);
    import i2c_host_pkg::*;

    host_state_t s;
    host_state_t n;
    logic tick;
    logic rdByte;
    logic [2:0] lastPh;

    // fixed quarter grid; scl is never read back, so a slave stretching the clock is not seen
    assign tick = (s.qCnt == QTR_CYC - 8'h01);
    assign rdByte = s.isRead && (s.step == 2'h3);
    assign lastPh = (s.st == ST_BYTE) ? BYTE_LAST_PH : COND_LAST_PH;

    always_comb begin
        n = s;
        n.sdaMeta = sdaIn;
        n.sdaSync = s.sdaMeta;
        n.done = 1'h0;
        // open drain: only the enable ever moves, the driven value stays low
        n.sdaOut = 1'h0;
        n.qCnt = tick ? 8'h00 : s.qCnt + 8'h01;
        if (tick) begin
            n.phase = (s.phase == lastPh) ? 3'h0 : s.phase + 3'h1;
        end
        case (s.st)
            ST_IDLE: begin
                n.qCnt = 8'h00;
                n.phase = 3'h0;
                if (req.valid) begin
                    n.st = ST_START;
                    n.isRead = req.read;
                    n.regAddr = req.regAddr;
                    n.wrData = req.wrData;
                    n.step = 2'h0;
                    n.nack = 1'h0;
                    n.ready = 1'h0;
                    n.sclOut = 1'h0;
                end
            end
            ST_START: begin
                // same sequence serves start and repeated start
                if (tick) begin
                    case (s.phase)
                        3'h0: n.sdaOe = 1'h0;
                        3'h1: n.sclOut = 1'h1;
                        3'h3: n.sdaOe = 1'h1; // two quarters clock high before and after
                        3'h5: begin
                            n.st = ST_BYTE;
                            n.sclOut = 1'h0;
                            n.bitCnt = 4'h0;
                            n.shift = {SLAVE_ADDR, (s.step == 2'h2) ? DIR_READ : DIR_WRITE};
                        end
                        default: ;
                    endcase
                end
            end
            ST_BYTE: begin
                if (tick) begin
                    case (s.phase)
                        3'h0: begin
                            // drive only after scl has been low a full quarter
                            if (s.bitCnt < BYTE_BITS && !rdByte) begin
                                n.sdaOe = ~s.shift[7];
                            end else begin
                                n.sdaOe = 1'h0;
                            end
                        end
                        3'h1: n.sclOut = 1'h1;
                        3'h3: begin
                            n.sclOut = 1'h0;
                            if (s.bitCnt < BYTE_BITS) begin
                                n.shift = {s.shift[6:0], s.sdaSync};
                                n.bitCnt = s.bitCnt + 4'h1;
                            end else begin
                                n.bitCnt = 4'h0;
                                // a high level in the ack slot of a written byte means the slave refused it
                                if (!rdByte && s.sdaSync) begin
                                    n.nack = 1'h1;
                                    n.st = ST_STOP;
                                end else begin
                                    case (s.step)
                                        2'h0: begin
                                            n.step = 2'h1;
                                            n.shift = s.regAddr;
                                        end
                                        2'h1: begin
                                            n.step = 2'h2;
                                            if (s.isRead) begin
                                                n.st = ST_START;
                                            end else begin
                                                n.shift = s.wrData;
                                            end
                                        end
                                        2'h2: begin
                                            if (s.isRead) begin
                                                n.step = 2'h3;
                                                n.shift = 8'h00;
                                            end else begin
                                                n.st = ST_STOP;
                                            end
                                        end
                                        default: begin
                                            n.rdData = s.shift;
                                            n.st = ST_STOP;
                                        end
                                    endcase
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_STOP: begin
                if (tick) begin
                    case (s.phase)
                        3'h0: n.sdaOe = 1'h1;
                        3'h1: n.sclOut = 1'h1;
                        3'h3: n.sdaOe = 1'h0;
                        3'h5: begin
                            // bus-free time is covered by the next start's lead-in
                            n.st = ST_IDLE;
                            n.done = 1'h1;
                            n.ready = 1'h1;
                        end
                        default: ;
                    endcase
                end
            end
            default: n = STATE_RST;
        endcase
    end

    // one register stage for all state keeps every output straight off a flop
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s <= STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign rsp = '{ready: s.ready, done: s.done, nack: s.nack, rdData: s.rdData};
    assign sdaOut = s.sdaOut;
    assign sdaOe = s.sdaOe;
    assign sclOut = s.sclOut;

    // protocol checks look at the flop values that drive the wires
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_sda_stable_high: assert property ((s.st == ST_BYTE && s.sclOut && $past(s.sclOut)) |-> $stable(s.sdaOe))
        else $error("data moved while clock high");
    chk_scl_on_tick: assert property (($changed(s.sclOut) && $past(s.st) != ST_IDLE) |-> $past(tick))
        else $error("clock edge off the quarter grid");
    chk_data_after_fall: assert property ((s.st == ST_BYTE && $changed(s.sdaOe)) |-> (s.phase == 3'h1 && !s.sclOut))
        else $error("data changed outside low phase");
    chk_byte_nine_slots: assert property ((s.st == ST_BYTE && tick && s.phase == 3'h3 && s.bitCnt == 4'h8) |=> s.bitCnt == 4'h0)
        else $error("byte did not end after ack slot");
    chk_msb_first: assert property ((s.st == ST_BYTE && s.phase == 3'h1 && $past(s.phase) == 3'h0 && s.bitCnt < 4'h8 && !rdByte) |-> s.sdaOe == ~s.shift[7])
        else $error("write bit not msb of shift");
    chk_addr_first: assert property (($past(s.st) == ST_START && s.st == ST_BYTE) |-> (s.shift[7:1] == SLAVE_ADDR && s.shift[0] == (s.step == 2'h2)))
        else $error("address byte wrong");
    chk_nack_stops: assert property ((s.st == ST_BYTE && tick && s.phase == 3'h3 && s.bitCnt == 4'h8 && !rdByte && s.sdaSync) |=> (s.st == ST_STOP && s.nack))
        else $error("slave nack did not lead to stop");
    chk_ack_released: assert property ((s.st == ST_BYTE && s.bitCnt == 4'h8 && s.phase != 3'h0) |-> !s.sdaOe)
        else $error("master drove data in ack slot");
    chk_read_nack: assert property ((s.st == ST_BYTE && rdByte && s.bitCnt == 4'h8 && s.sclOut) |-> !s.sdaOe ##1 !s.sdaOe)
        else $error("last read byte acknowledged");
    chk_cond_scl_high: assert property (($changed(s.sdaOe) && s.sclOut) |-> (s.st == ST_START || s.st == ST_STOP))
        else $error("data edge with clock high outside condition");
    chk_restart_read: assert property ((s.st == ST_BYTE && s.isRead && s.step == 2'h1 && tick && s.phase == 3'h3 && s.bitCnt == 4'h8 && !s.sdaSync) |=> s.st == ST_START)
        else $error("read did not restart");
    chk_rate_limit: assert property (s.qCnt < QTR_CYC)
        else $error("quarter counter overran");
    chk_scl_high_min: assert property ($rose(s.sclOut) |-> ##300 s.sclOut)
        else $error("clock high period too short");
    chk_scl_low_min: assert property ($fell(s.sclOut) |-> ##300 !s.sclOut)
        else $error("clock low period too short");
    chk_idle_released: assert property (s.st == ST_IDLE |-> (!s.sdaOe && s.sclOut))
        else $error("bus not released while idle");

    // main scenarios: plain write, read with restart, refused address, restart itself

    cov_write_done: cover property (s.done && !s.isRead && !s.nack);
    cov_read_done: cover property (s.done && s.isRead && !s.nack);
    cov_nack_abort: cover property (s.done && s.nack);
    cov_restart: cover property ($past(s.st) == ST_BYTE && s.st == ST_START);
endmodule

// ---- shared/i2c_host_pkg.sv ----
// types and constants for the two-wire register host
// assumes a 100 MHz mclk and a single register slave on the wires
package i2c_host_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 10000;
    localparam logic [7:0] QTR_CYC = 8'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));
    localparam logic [6:0] SLAVE_ADDR = 7'h58;
    localparam logic DIR_READ = 1'h1;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] BYTE_LAST_PH = 3'h3;
    localparam logic [2:0] COND_LAST_PH = 3'h5;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_BYTE = 4'h4,
        ST_STOP = 4'h8
    } host_st_t;

    typedef struct packed {
        logic valid;
        logic read;
        logic [7:0] regAddr;
        logic [7:0] wrData;
    } req_t;

    typedef struct packed {
        logic ready;
        logic done;
        logic nack;
        logic [7:0] rdData;
    } rsp_t;

    typedef struct packed {
        host_st_t st;
        logic [2:0] phase;
        logic [7:0] qCnt;
        logic [3:0] bitCnt;
        logic [1:0] step;
        logic [7:0] shift;
        logic isRead;
        logic [7:0] regAddr;
        logic [7:0] wrData;
        logic sclOut;
        logic sdaOe;
        logic sdaOut;
        logic sdaMeta;
        logic sdaSync;
        logic ready;
        logic done;
        logic nack;
        logic [7:0] rdData;
    } host_state_t;

    localparam host_state_t STATE_RST = '{
        st: ST_IDLE, phase: 3'h0, qCnt: 8'h00, bitCnt: 4'h0, step: 2'h0,
        shift: 8'h00, isRead: 1'h0, regAddr: 8'h00, wrData: 8'h00,
        sclOut: 1'h1, sdaOe: 1'h0, sdaOut: 1'h0, sdaMeta: 1'h1, sdaSync: 1'h1,
        ready: 1'h1, done: 1'h0, nack: 1'h0, rdData: 8'h00
    };
endpackage

// ---- test/i2c_reg_host_tb.sv ----
// self-checking bench for the two-wire register host
// assumes the slave model in this folder and a pull-up on the data wire
`timescale 1ns/1ns
module i2c_reg_host_tb;
    import i2c_host_pkg::*;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    req_t req = '0;
    rsp_t rsp;
    logic sdaOut;
    logic sdaOe;
    logic sclOut;
    logic sPull;
    logic [6:0] devAddr = SLAVE_ADDR;
    wire sdaWire = ~(sdaOe | sPull);
    int num_errors = 0;
    int check_count = 0;

    always #5 mclk = ~mclk;

    i2c_reg_host u_i2c_reg_host (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut));
    i2c_slave_model u_i2c_slave_model (.scl(sclOut), .sda(sdaWire), .devAddr(devAddr), .sdaPull(sPull));

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one transfer; waits for the done pulse under a bound
    task automatic run(logic rd, logic [7:0] ra, logic [7:0] wd);
        int i;
        @(posedge mclk);
        #1 req = '{valid: 1'h1, read: rd, regAddr: ra, wrData: wd};
        @(posedge mclk);
        #1 req.valid = 1'h0;
        for (i = 0; i < 45000 && rsp.done !== 1'h1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (rsp.done !== 1'h1) begin
            check("done in time", rsp.done, 8'h01);
            summarize();
        end
        check("ready at done", rsp.ready, 8'h01);
    endtask

    task automatic test_reset();
        check("reset ready", rsp.ready, 8'h01);
        check("reset clock", sclOut, 8'h01);
        check("reset drive", sdaOut, 8'h00);
        check("reset release", sdaOe, 8'h00);
        $display("test reset done");
    endtask

    // data and register values are not bit palindromes, so a reversed bit order shows
    task automatic test_write();
        run(1'h0, 8'h2C, 8'h6B);
        check("written byte", u_i2c_slave_model.mem[8'h2C], 8'h6B);
        check("write nack", rsp.nack, 8'h00);
        $display("test write done");
    endtask

    task automatic test_read();
        u_i2c_slave_model.mem[8'h3D] = 8'h5A;
        run(1'h1, 8'h2C, 8'h00);
        check("read byte", rsp.rdData, 8'h6B);
        check("read nack", rsp.nack, 8'h00);
        check("idle clock", sclOut, 8'h01);
        $display("test read done");
    endtask

    task automatic test_nack();
        devAddr = 7'h59;
        run(1'h0, 8'h3D, 8'hFF);
        check("address nack", rsp.nack, 8'h01);
        check("untouched byte", u_i2c_slave_model.mem[8'h3D], 8'h5A);
        check("held read byte", rsp.rdData, 8'h6B);
        check("released data", sdaOe, 8'h00);
        devAddr = SLAVE_ADDR;
        $display("test nack done");
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        #1 sys_rst = 1'h0;
        test_reset();
        test_write();
        test_read();
        test_nack();
        summarize();
    end
endmodule

// ---- test/i2c_slave_model.sv ----
// behavioural register slave on the two wires, facing the host
// assumes a pulled-up data wire resolved by the bench; scl comes from the host
`timescale 1ns/1ns
module i2c_slave_model (
    input wire logic scl, // clock wire
    input wire logic sda, // resolved data wire
    input wire logic [6:0] devAddr, // address this slave answers to
    output logic sdaPull // pull data wire low when high
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    int cnt;
    int idx;
    logic act;
    logic rd;
    logic tx;

    initial begin
        sdaPull = 1'h0;
        act = 1'h0;
        ptr = 8'h00;
    end

    // a repeated start restarts address reception; ptr is kept on purpose
    always @(negedge sda) if (scl) begin
        act = 1'h1;
        cnt = 0;
        idx = 0;
        tx = 1'h0;
        rd = 1'h0;
    end

    always @(posedge sda) if (scl) act = 1'h0;

    always @(posedge scl) if (act) begin
        if (cnt < 8 && !tx) sh = {sh[6:0], sda};
        if (cnt == 9 && tx && sda) act = 1'h0;
        if (cnt < 8) cnt++;
    end

    // drive only in ack slots and read bits, always changing while scl is low
    always @(negedge scl) if (act) begin
        if (cnt == 9) begin
            cnt = 0;
            idx++;
            // one assignment only, so the wire sees no zero-width glitch
            tx = rd;
            sdaPull = rd ? ~mem[ptr][7] : 1'h0;
        end else if (cnt == 8 && tx) begin
            sdaPull = 1'h0;
            cnt = 9;
        end else if (cnt == 8) begin
            cnt = 9;
            if (idx == 0) begin
                if (sh[7:1] == devAddr) begin
                    sdaPull = 1'h1;
                    rd = sh[0];
                end else begin
                    act = 1'h0;
                end
            end else if (idx == 1) begin
                ptr = sh;
                sdaPull = 1'h1;
            end else begin
                mem[ptr] = sh;
                sdaPull = 1'h1;
            end
        end else if (tx) begin
            sdaPull = ~mem[ptr][7 - cnt];
        end
    end
endmodule
